// ==== ima_tc_interrupt_hierarchy_bench.sv ====
// self-checking bench for the interrupt hierarchy
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module ima_tc_interrupt_hierarchy_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, ce, cpu_wr, cpu_rd, irq_n;
  logic [11:0] cpu_addr;
  logic [15:0] cpu_wdata, cpu_rdata, rv, m;
  logic [15:0] dd_in, fl_in, cd_in, dd_out, fl_out, cd_out, pre_ovf, chg, viol, tc_fifo;
  logic [15:0][11:0] tc_wrap, tc_ien;
  logic [7:0][3:0] g_wrap, g_ien;
  logic [7:0] g_fifo, tx_done, tx_fend;
  logic [15:0] en [16];
  int fail_count, tests_run, lk, k, b, c, g, s;
  int kb [9] = '{imai_pkg::LS_DD_IN, imai_pkg::LS_FL_IN, imai_pkg::LS_CD_IN, imai_pkg::LS_VIOL, imai_pkg::LS_CHG,
                 imai_pkg::LS_PRE_OVF, imai_pkg::LS_DD_OUT, imai_pkg::LS_FL_OUT, imai_pkg::LS_CD_OUT};
  logic [11:0] rst_addr [7] = '{imai_pkg::ADDR_TX_HANDLER, imai_pkg::ADDR_LINK_STAT, imai_pkg::ADDR_LINK_EN,
                               imai_pkg::ADDR_MASTER_EN, imai_pkg::ADDR_MASTER_STAT, imai_pkg::ADDR_GRP_SUMMARY,
                               imai_pkg::ADDR_TC_OVF_STAT};

  imai_irq_top u_imai_irq_top (.clk(clk), .rst(rst), .ce(ce), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
    .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata), .irq_n(irq_n),
    .delay_desync_condition_enter(dd_in), .frame_loss_condition_enter(fl_in), .cell_delineation_loss_enter(cd_in),
    .delay_desync_condition_exit(dd_out), .frame_loss_condition_exit(fl_out), .cell_delineation_loss_exit(cd_out),
    .preproc_mem_ovf(pre_ovf), .ctrl_cell_changed(chg), .ctrl_cell_violation(viol), .tc_cnt_wrap(tc_wrap),
    .tc_cnt_irq_en(tc_ien), .tc_fifo_ovf(tc_fifo), .grp_cnt_wrap(g_wrap), .grp_cnt_irq_en(g_ien),
    .grp_fifo_ovf(g_fifo), .tx_cell_done(tx_done), .tx_frame_end(tx_fend));

  // ----------------------------------------
  // clock, helpers
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  function automatic logic [15:0] exp_handler(input int gi);
    exp_handler = (16'h0001 << (imai_pkg::TXH_READY_LSB + gi)) | (16'h0001 << gi);
  endfunction

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    cpu_addr = a;
    cpu_wdata = d;
    cpu_wr = 1'b1;
    tick();
    cpu_wr = 1'b0;
    tick();
  endtask

  task automatic rd(input logic [11:0] a, output logic [15:0] d);
    cpu_addr = a;
    cpu_rd = 1'b1;
    tick();
    cpu_rd = 1'b0;
    d = cpu_rdata;
    tick();
  endtask

  task automatic pulse(input int kk, input int l);
    case (kk)
      0: dd_in[l] = 1'b1;
      1: fl_in[l] = 1'b1;
      2: cd_in[l] = 1'b1;
      3: viol[l] = 1'b1;
      4: chg[l] = 1'b1;
      5: pre_ovf[l] = 1'b1;
      6: dd_out[l] = 1'b1;
      7: fl_out[l] = 1'b1;
      default: cd_out[l] = 1'b1;
    endcase
    tick();
    {dd_in, fl_in, cd_in, viol, chg, pre_ovf, dd_out, fl_out, cd_out} = '0;
  endtask

  task automatic finish_test();
    if (fail_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    finish_test();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(56650));
    {cpu_wr, cpu_rd, cpu_addr, cpu_wdata} = '0;
    rst = 1'b1;
    ce = 1'b1;
    {dd_in, fl_in, cd_in, viol, chg, pre_ovf, dd_out, fl_out, cd_out, tc_fifo} = '0;
    {tc_wrap, tc_ien, g_wrap, g_ien, g_fifo, tx_done, tx_fend} = '0;
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    foreach (rst_addr[i]) begin
      rd(rst_addr[i], rv);
      `CHK(rv, imai_pkg::REG_RST)
    end
    `CHK(irq_n, imai_pkg::IRQ_IDLE)
    for (lk = 0; lk < 16; lk++) begin
      en[lk] = 16'($urandom) & 16'h0FFF;
      wr(imai_pkg::ADDR_LINK_EN + 12'(lk), en[lk]);
    end
    for (lk = 0; lk < 16; lk++) begin
      rd(imai_pkg::ADDR_LINK_EN + 12'(lk), rv);
      `CHK(rv, en[lk])
      wr(imai_pkg::ADDR_LINK_EN + 12'(lk), 16'h0000);
    end
    wr(12'h7FF, 16'hFFFF);
    rd(12'h7FF, rv);
    `CHK(rv, 16'h0000)
    ce = 1'b0;
    wr(imai_pkg::ADDR_MASTER_EN, 16'hFFFF);
    ce = 1'b1;
    rd(imai_pkg::ADDR_MASTER_EN, rv);
    `CHK(rv, 16'h0000)
    // latched events with every enable low
    for (k = 0; k < 9; k++) begin
      lk = (k == 6) ? 3 : $urandom_range(15);
      m = 16'h0001 << kb[k];
      pulse(k, lk);
      rd(imai_pkg::ADDR_LINK_STAT + 12'(lk), rv);
      `CHK(rv, m)
      rd(imai_pkg::ADDR_LINK_STAT + 12'(lk), rv);
      `CHK(rv, m)
      wr(imai_pkg::ADDR_LINK_STAT + 12'(lk), 16'hFFFF);
      rd(imai_pkg::ADDR_LINK_STAT + 12'(lk), rv);
      `CHK(rv, m)
      wr(imai_pkg::ADDR_LINK_STAT + 12'(lk), ~m);
      rd(imai_pkg::ADDR_LINK_STAT + 12'(lk), rv);
      `CHK(rv, 16'h0000)
    end
    // interrupt path through link and master enables
    lk = 4;
    k = $urandom_range(8);
    m = 16'h0001 << kb[k];
    wr(imai_pkg::ADDR_MASTER_EN, 16'h0001 << lk);
    wr(imai_pkg::ADDR_LINK_EN + 12'(lk), ~m & 16'h0FFF);
    pulse(k, lk);
    repeat (2) tick();
    `CHK(irq_n, 1'b1)
    rd(imai_pkg::ADDR_MASTER_STAT, rv);
    `CHK(rv, 16'h0000)
    wr(imai_pkg::ADDR_LINK_EN + 12'(lk), m);
    repeat (2) tick();
    `CHK(irq_n, 1'b0)
    rd(imai_pkg::ADDR_MASTER_STAT, rv);
    `CHK(rv, 16'h0001 << lk)
    wr(imai_pkg::ADDR_MASTER_STAT, 16'h0000);
    repeat (2) tick();
    `CHK(irq_n, 1'b0)
    wr(imai_pkg::ADDR_MASTER_EN, 16'h0000);
    repeat (2) tick();
    `CHK(irq_n, 1'b1)
    wr(imai_pkg::ADDR_MASTER_EN, 16'h0001 << lk);
    wr(imai_pkg::ADDR_LINK_EN + 12'(lk), 16'h0000);
    repeat (2) tick();
    `CHK(irq_n, 1'b1)
    wr(imai_pkg::ADDR_LINK_STAT + 12'(lk), 16'h0000);
    wr(imai_pkg::ADDR_MASTER_EN, 16'h0000);
    // link bit 0 from the thirteen overflow sources
    for (c = 0; c < 13; c++) begin
      lk = $urandom_range(15);
      tc_ien[lk] = 12'hFFF;
      if (c == imai_pkg::TC_FIFO) tc_fifo[lk] = 1'b1;
      else tc_wrap[lk][c] = 1'b1;
      tick();
      {tc_fifo, tc_wrap} = '0;
      rd(imai_pkg::ADDR_TC_OVF_STAT + 12'(lk), rv);
      `CHK(rv, 16'h0001 << c)
      rd(imai_pkg::ADDR_LINK_STAT + 12'(lk), rv);
      `CHK(rv, 16'h0000)
      wr(imai_pkg::ADDR_TC_OVF_EN, 16'h0001 << lk);
      wr(imai_pkg::ADDR_LINK_STAT + 12'(lk), 16'h0000);
      rd(imai_pkg::ADDR_LINK_STAT + 12'(lk), rv);
      `CHK(rv, 16'h0001)
      if (c < imai_pkg::TC_CNT) begin
        tc_ien[lk][c] = 1'b0;
        tick();
        rd(imai_pkg::ADDR_LINK_STAT + 12'(lk), rv);
        `CHK(rv, 16'h0000)
      end
      wr(imai_pkg::ADDR_TC_OVF_STAT + 12'(lk), 16'h0000);
      tc_ien[lk] = 12'hFFF;
      tick();
      rd(imai_pkg::ADDR_LINK_STAT + 12'(lk), rv);
      `CHK(rv, 16'h0000)
      wr(imai_pkg::ADDR_TC_OVF_EN, 16'h0000);
      tc_ien = '0;
    end
    // group overflow levels and link 0 bit 8
    for (g = 0; g < 8; g++) begin
      s = $urandom_range(4);
      g_ien[g] = 4'hF;
      if (s == imai_pkg::GL_FIFO) g_fifo[g] = 1'b1;
      else g_wrap[g][s] = 1'b1;
      tick();
      {g_fifo, g_wrap} = '0;
      wr(imai_pkg::ADDR_GRP_LOW_STAT + 12'(g), 16'h001F);
      rd(imai_pkg::ADDR_GRP_LOW_STAT + 12'(g), rv);
      `CHK(rv, 16'h0001 << s)
      rd(imai_pkg::ADDR_GRP_SUMMARY, rv);
      `CHK(rv, 16'h0000)
      wr(imai_pkg::ADDR_GRP_OVF_EN, 16'h0001 << g);
      wr(imai_pkg::ADDR_GRP_FIFO_EN, 16'h0001 << g);
      rd(imai_pkg::ADDR_GRP_SUMMARY, rv);
      `CHK(rv, 16'h0001 << g)
      rd(imai_pkg::ADDR_LINK_STAT, rv);
      `CHK(rv, 16'h0100)
      if (s == imai_pkg::GL_FIFO) wr(imai_pkg::ADDR_GRP_FIFO_EN, 16'h0000);
      else g_ien[g][s] = 1'b0;
      tick();
      rd(imai_pkg::ADDR_LINK_STAT, rv);
      `CHK(rv, 16'h0000)
      wr(imai_pkg::ADDR_GRP_LOW_STAT + 12'(g), 16'h0000);
      rd(imai_pkg::ADDR_GRP_LOW_STAT + 12'(g), rv);
      `CHK(rv, 16'h0000)
      wr(imai_pkg::ADDR_GRP_OVF_EN, 16'h0000);
      wr(imai_pkg::ADDR_GRP_FIFO_EN, 16'h0000);
      g_ien = '0;
    end
    // transmit events and link 0 bit 7
    for (g = 0; g < 8; g++) begin
      tx_done[g] = 1'b1;
      tx_fend[g] = 1'b1;
      tick();
      {tx_done, tx_fend} = '0;
      rd(imai_pkg::ADDR_TX_HANDLER, rv);
      `CHK(rv, exp_handler(g))
      wr(imai_pkg::ADDR_TX_CC_EN, 16'h0001 << g);
      rd(imai_pkg::ADDR_LINK_STAT, rv);
      `CHK(rv, 16'h0000)
      wr(imai_pkg::ADDR_TX_FR_EN, 16'h0001 << g);
      rd(imai_pkg::ADDR_LINK_STAT, rv);
      `CHK(rv, 16'h0080)
      wr(imai_pkg::ADDR_TX_HANDLER, 16'hFFFF);
      rd(imai_pkg::ADDR_TX_HANDLER, rv);
      `CHK(rv, exp_handler(g))
      wr(imai_pkg::ADDR_TX_HANDLER, 16'h0000);
      rd(imai_pkg::ADDR_TX_HANDLER, rv);
      `CHK(rv, 16'h0000)
      rd(imai_pkg::ADDR_LINK_STAT, rv);
      `CHK(rv, 16'h0000)
      wr(imai_pkg::ADDR_TX_CC_EN, 16'h0000);
      wr(imai_pkg::ADDR_TX_FR_EN, 16'h0000);
    end
    finish_test();
  end
endmodule

// ==== imai_bus_if.sv ====
// internal register write bus to the register banks
interface imai_bus_if;
  logic [11:0] addr;
  logic [15:0] wdata;
  logic wr;
  logic ce;
  modport ctrl (output addr, output wdata, output wr, output ce);
  modport bank (input addr, input wdata, input wr, input ce);
endinterface

// ==== imai_irq_top.sv ====
// interrupt hierarchy: link, group and master levels
// How it works
// - irq_n low when an enabled master status bit is set, else high.
// - master status bit per link is live OR of enabled link status bits.
// - master status access never changes irq; it falls with source or enables.
// - sixteen link status and sixteen link enable registers at consecutive addresses.
// - bits 11,10,9 latch on leaving desync, frame loss, delineation loss.
// - bits 6,5,4 latch on preprocess overflow, changed cell, cell violation.
// - bits 3,2,1 latch on entering desync, frame loss, delineation loss.
// - bit 0 is live OR of enabled TC counter and FIFO overflows.
// - counter wrap to zero raises its overflow request.
// - bit 0 falls on counter mask, status clear, or TC enable clear.
// - reading link status changes nothing.
// - write zero clears latched bits; writing one or bit 0 does nothing.
// - link source propagates only with its link enable bit set.
// - link 0 bit 8 is live OR of enabled group overflows.
// - link 0 bit 7 reports transfer done or frame end per group.
// - group event needs both its cell and frame enables set.
// - handler register: ready sets on completion, frame bits clear by zero.
// - TC overflow status: bit 12 FIFO, 11:8 input, 7:4 tx, 3:0 rx.
// - group summary bit shows enabled overflow of that group.
// - eight five-bit group low-level overflow status registers.
// - group overflow enable passes or blocks the group upward.
// - group low-level bits latch; only a zero write clears them.
module imai_irq_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [11:0] cpu_addr,
  input wire logic [15:0] cpu_wdata,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  output logic [15:0] cpu_rdata,
  output logic irq_n,
  input wire logic [15:0] delay_desync_condition_enter,
  input wire logic [15:0] frame_loss_condition_enter,
  input wire logic [15:0] cell_delineation_loss_enter,
  input wire logic [15:0] delay_desync_condition_exit,
  input wire logic [15:0] frame_loss_condition_exit,
  input wire logic [15:0] cell_delineation_loss_exit,
  input wire logic [15:0] preproc_mem_ovf,
  input wire logic [15:0] ctrl_cell_changed,
  input wire logic [15:0] ctrl_cell_violation,
  input wire logic [15:0][11:0] tc_cnt_wrap,
  input wire logic [15:0][11:0] tc_cnt_irq_en,
  input wire logic [15:0] tc_fifo_ovf,
  input wire logic [7:0][3:0] grp_cnt_wrap,
  input wire logic [7:0][3:0] grp_cnt_irq_en,
  input wire logic [7:0] grp_fifo_ovf,
  input wire logic [7:0] tx_cell_done,
  input wire logic [7:0] tx_frame_end
);

  // ----------------------------------------
  // state and wiring
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] rdata;
    logic irq_n;
  } imai_top_s;

  imai_top_s st_ff;
  imai_top_s nxt_st;

  imai_bus_if bus ();

  logic [15:0][11:0] ls_set;
  logic [15:0][11:0] ls_q;
  logic [15:0][11:0] ls_view;
  logic [15:0][11:0] len_q;
  logic [15:0][12:0] tc_set;
  logic [15:0][12:0] tc_q;
  logic [7:0][4:0] gl_set;
  logic [7:0][4:0] gl_q;
  logic [0:0][15:0] txh_set;
  logic [0:0][15:0] txh_q;
  logic [0:0][15:0] men_q;
  logic [0:0][15:0] tcen_q;
  logic [0:0][7:0] gen_q;
  logic [0:0][7:0] gfen_q;
  logic [0:0][7:0] ccen_q;
  logic [0:0][7:0] fren_q;
  logic [15:0] tc_req;
  logic [7:0] grp_summary;
  logic grp_any;
  logic tx_event;
  logic [15:0] master_stat;
  logic [15:0] rd_word;

  assign bus.addr = cpu_addr;
  assign bus.wdata = cpu_wdata;
  assign bus.wr = cpu_wr;
  assign bus.ce = ce;

  // ----------------------------------------
  // event capture vectors
  // ----------------------------------------
  always_comb begin
    for (int i = 0; i < imai_pkg::NLINK; i++) begin
      ls_set[i] = '0;
      ls_set[i][imai_pkg::LS_DD_OUT] = delay_desync_condition_exit[i];
      ls_set[i][imai_pkg::LS_FL_OUT] = frame_loss_condition_exit[i];
      ls_set[i][imai_pkg::LS_CD_OUT] = cell_delineation_loss_exit[i];
      ls_set[i][imai_pkg::LS_PRE_OVF] = preproc_mem_ovf[i];
      ls_set[i][imai_pkg::LS_CHG] = ctrl_cell_changed[i];
      ls_set[i][imai_pkg::LS_VIOL] = ctrl_cell_violation[i];
      ls_set[i][imai_pkg::LS_DD_IN] = delay_desync_condition_enter[i];
      ls_set[i][imai_pkg::LS_FL_IN] = frame_loss_condition_enter[i];
      ls_set[i][imai_pkg::LS_CD_IN] = cell_delineation_loss_enter[i];
      tc_set[i] = {tc_fifo_ovf[i], tc_cnt_wrap[i]};
    end
    for (int g = 0; g < imai_pkg::NGRP; g++) begin
      gl_set[g] = {grp_fifo_ovf[g], grp_cnt_wrap[g]};
    end
    // ready high byte, frame low byte
    txh_set[0] = {tx_cell_done, tx_frame_end};
  end

  // ----------------------------------------
  // register banks
  // ----------------------------------------
  // link status block
  imai_latch_bank #(.N(16), .W(12), .BASE(imai_pkg::ADDR_LINK_STAT), .MASK(imai_pkg::LS_LATCH_MASK)) u_link_stat (
    .clk(clk),
    .rst(rst),
    .bus(bus),
    .set(ls_set),
    .q(ls_q)
  );

  imai_rw_bank #(.N(16), .W(12), .BASE(imai_pkg::ADDR_LINK_EN)) u_link_en (
    .clk(clk),
    .rst(rst),
    .bus(bus),
    .q(len_q)
  );

  imai_latch_bank #(.N(16), .W(13), .BASE(imai_pkg::ADDR_TC_OVF_STAT)) u_tc_stat (
    .clk(clk),
    .rst(rst),
    .bus(bus),
    .set(tc_set),
    .q(tc_q)
  );

  imai_latch_bank #(.N(8), .W(5), .BASE(imai_pkg::ADDR_GRP_LOW_STAT)) u_grp_stat (
    .clk(clk),
    .rst(rst),
    .bus(bus),
    .set(gl_set),
    .q(gl_q)
  );

  imai_latch_bank #(.N(1), .W(16), .BASE(imai_pkg::ADDR_TX_HANDLER)) u_tx_handler (
    .clk(clk),
    .rst(rst),
    .bus(bus),
    .set(txh_set),
    .q(txh_q)
  );

  imai_rw_bank #(.N(1), .W(16), .BASE(imai_pkg::ADDR_MASTER_EN)) u_master_en (
    .clk(clk),
    .rst(rst),
    .bus(bus),
    .q(men_q)
  );

  imai_rw_bank #(.N(1), .W(16), .BASE(imai_pkg::ADDR_TC_OVF_EN)) u_tc_en (
    .clk(clk),
    .rst(rst),
    .bus(bus),
    .q(tcen_q)
  );

  imai_rw_bank #(.N(1), .W(8), .BASE(imai_pkg::ADDR_GRP_OVF_EN)) u_grp_en (
    .clk(clk),
    .rst(rst),
    .bus(bus),
    .q(gen_q)
  );

  imai_rw_bank #(.N(1), .W(8), .BASE(imai_pkg::ADDR_GRP_FIFO_EN)) u_grp_fifo_en (
    .clk(clk),
    .rst(rst),
    .bus(bus),
    .q(gfen_q)
  );

  imai_rw_bank #(.N(1), .W(8), .BASE(imai_pkg::ADDR_TX_CC_EN)) u_cc_en (
    .clk(clk),
    .rst(rst),
    .bus(bus),
    .q(ccen_q)
  );

  imai_rw_bank #(.N(1), .W(8), .BASE(imai_pkg::ADDR_TX_FR_EN)) u_fr_en (
    .clk(clk),
    .rst(rst),
    .bus(bus),
    .q(fren_q)
  );

  // ----------------------------------------
  // hierarchy summaries
  // ----------------------------------------
  always_comb begin
    for (int i = 0; i < imai_pkg::NLINK; i++) begin
      // counter mask, status and the link's TC overflow enable bit
      tc_req[i] = (|(tc_q[i] & {1'b1, tc_cnt_irq_en[i]})) & tcen_q[0][i];
    end
    for (int g = 0; g < imai_pkg::NGRP; g++) begin
      grp_summary[g] = (|(gl_q[g] & {gfen_q[0][g], grp_cnt_irq_en[g]})) & gen_q[0][g];
    end
    grp_any = |grp_summary;
    tx_event = |((txh_q[0][15:8] | txh_q[0][7:0]) & ccen_q[0] & fren_q[0]);
    for (int i = 0; i < imai_pkg::NLINK; i++) begin
      ls_view[i] = ls_q[i];
      ls_view[i][imai_pkg::LS_OVF] = tc_req[i];
    end
    ls_view[0][imai_pkg::LS_GRP_OVF] = grp_any;
    ls_view[0][imai_pkg::LS_TXEV] = tx_event;
    for (int i = 0; i < imai_pkg::NLINK; i++) begin
      master_stat[i] = |(ls_view[i] & len_q[i]);
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always_comb begin
    rd_word = imai_pkg::REG_RST;
    for (int i = 0; i < imai_pkg::NLINK; i++) begin
      if (imai_pkg::reg_hit(cpu_addr, imai_pkg::ADDR_LINK_STAT, i)) begin
        rd_word = 16'(ls_view[i]);
      end
      if (imai_pkg::reg_hit(cpu_addr, imai_pkg::ADDR_LINK_EN, i)) begin
        rd_word = 16'(len_q[i]);
      end
      if (imai_pkg::reg_hit(cpu_addr, imai_pkg::ADDR_TC_OVF_STAT, i)) begin
        rd_word = 16'(tc_q[i]);
      end
    end
    for (int g = 0; g < imai_pkg::NGRP; g++) begin
      if (imai_pkg::reg_hit(cpu_addr, imai_pkg::ADDR_GRP_LOW_STAT, g)) begin
        rd_word = 16'(gl_q[g]);
      end
    end
    case (cpu_addr)
      imai_pkg::ADDR_TX_HANDLER: rd_word = txh_q[0];
      imai_pkg::ADDR_TX_CC_EN: rd_word = 16'(ccen_q[0]);
      imai_pkg::ADDR_TX_FR_EN: rd_word = 16'(fren_q[0]);
      imai_pkg::ADDR_GRP_OVF_EN: rd_word = 16'(gen_q[0]);
      imai_pkg::ADDR_GRP_FIFO_EN: rd_word = 16'(gfen_q[0]);
      imai_pkg::ADDR_MASTER_EN: rd_word = men_q[0];
      imai_pkg::ADDR_TC_OVF_EN: rd_word = tcen_q[0];
      imai_pkg::ADDR_MASTER_STAT: rd_word = master_stat;
      imai_pkg::ADDR_GRP_SUMMARY: rd_word = 16'(grp_summary);
      default: rd_word = rd_word;
    endcase
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;
    if (cpu_rd) begin
      nxt_st.rdata = rd_word;
    end
    // enabled master bit drives irq low
    nxt_st.irq_n = ~|(master_stat & men_q[0]);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '{rdata: imai_pkg::REG_RST, irq_n: imai_pkg::IRQ_IDLE};
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign cpu_rdata = st_ff.rdata;
  assign irq_n = st_ff.irq_n;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_irq_level;
    ce |=> irq_n == !$past(|(master_stat & men_q[0]));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq level wrong");

  property p_link_gate;
    len_q[2] == 12'h000 |-> !master_stat[2];
  endproperty
  a_link_gate: assert property (p_link_gate) else $error("disabled link reported");

  property p_master_live;
    (ls_view[4] & len_q[4]) != 12'h000 |-> master_stat[4];
  endproperty
  a_master_live: assert property (p_master_live) else $error("master bit missed");

  property p_mstat_write;
    ce && cpu_wr && cpu_addr == imai_pkg::ADDR_MASTER_STAT |=> $stable(men_q) && $stable(len_q);
  endproperty
  a_mstat_write: assert property (p_mstat_write) else $error("master status write had effect");

  sequence s_exit_seen;
    ce && delay_desync_condition_exit[3];
  endsequence
  sequence s_exit_held;
    ls_view[3][imai_pkg::LS_DD_OUT] ##1 (cpu_wr || !ce || ls_view[3][imai_pkg::LS_DD_OUT]);
  endsequence
  property p_exit_latch;
    s_exit_seen |=> s_exit_held;
  endproperty
  a_exit_latch: assert property (p_exit_latch) else $error("exit event not held");

  property p_read_quiet;
    ce && cpu_rd && !cpu_wr |=> (ls_q[0] & $past(ls_q[0])) == $past(ls_q[0]);
  endproperty
  a_read_quiet: assert property (p_read_quiet) else $error("read changed status");

  property p_bit0_live;
    !tc_req[5] |-> !ls_view[5][imai_pkg::LS_OVF];
  endproperty
  a_bit0_live: assert property (p_bit0_live) else $error("bit 0 latched");

  property p_grp_gate;
    !gen_q[0][3] |-> !grp_summary[3] && (grp_summary == 8'h00 || ls_view[0][imai_pkg::LS_GRP_OVF]);
  endproperty
  a_grp_gate: assert property (p_grp_gate) else $error("group gating wrong");

  property p_tx_both;
    (ccen_q[0] & fren_q[0]) == 8'h00 |-> !ls_view[0][imai_pkg::LS_TXEV];
  endproperty
  a_tx_both: assert property (p_tx_both) else $error("tx event without both enables");

  property p_len_write;
    ce && cpu_wr && imai_pkg::reg_hit(cpu_addr, imai_pkg::ADDR_LINK_EN, 5) |=> len_q[5] == $past(cpu_wdata[11:0]);
  endproperty
  a_len_write: assert property (p_len_write) else $error("link enable not at address");

endmodule

// ==== imai_latch_bank.sv ====
// bank of sticky status registers, cleared by writing zero
module imai_latch_bank #(
  parameter int N = 1,
  parameter int W = 16,
  parameter logic [11:0] BASE = 12'h000,
  parameter logic [W-1:0] MASK = '1
) (
  input wire logic clk,
  input wire logic rst,
  imai_bus_if.bank bus,
  input wire logic [N-1:0][W-1:0] set,
  output logic [N-1:0][W-1:0] q
);

  typedef struct packed {
    logic [N-1:0][W-1:0] q;
  } imai_lb_s;

  imai_lb_s st_ff;
  imai_lb_s nxt_st;

  // ----------------------------------------
  // set and clear
  // ----------------------------------------
  always_comb begin
    logic [W-1:0] clr;
    clr = '0;
    nxt_st = st_ff;
    for (int i = 0; i < N; i++) begin
      clr = '0;
      if (bus.wr && imai_pkg::reg_hit(bus.addr, BASE, i)) begin
        clr = ~bus.wdata[W-1:0];
      end
      nxt_st.q[i] = ((st_ff.q[i] & ~clr) | set[i]) & MASK;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '{q: '{default: imai_pkg::REG_RST[W-1:0]}};
    end else if (bus.ce) begin
      st_ff <= nxt_st;
    end
  end

  assign q = st_ff.q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_set_wins;
    bus.ce && |(set[0] & MASK) |=> |(st_ff.q[0] & $past(set[0] & MASK));
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("status event lost");

  property p_one_keeps;
    bus.ce && bus.wr && imai_pkg::reg_hit(bus.addr, BASE, 0) && (bus.wdata[W-1:0] == '1)
      |=> (st_ff.q[0] & $past(st_ff.q[0])) == $past(st_ff.q[0]);
  endproperty
  a_one_keeps: assert property (p_one_keeps) else $error("write of one changed status");

endmodule

// ==== imai_pkg.sv ====
// shared constants of the interrupt hierarchy
package imai_pkg;

  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int NLINK = 16;
  localparam int NGRP = 8;
  localparam int AW = 12;
  localparam int DW = 16;
  localparam int LS_W = 12;
  localparam int TC_W = 13;
  localparam int TC_CNT = 12;
  localparam int GL_W = 5;
  localparam int GL_CNT = 4;

  // ----------------------------------------
  // register addresses
  // ----------------------------------------
  localparam logic [11:0] ADDR_TX_HANDLER = 12'h086;
  localparam logic [11:0] ADDR_TX_CC_EN = 12'h088;
  localparam logic [11:0] ADDR_TX_FR_EN = 12'h089;
  localparam logic [11:0] ADDR_GRP_OVF_EN = 12'h40B;
  localparam logic [11:0] ADDR_GRP_FIFO_EN = 12'h40C;
  localparam logic [11:0] ADDR_TC_OVF_STAT = 12'h410;
  localparam logic [11:0] ADDR_GRP_LOW_STAT = 12'h420;
  localparam logic [11:0] ADDR_MASTER_EN = 12'h433;
  localparam logic [11:0] ADDR_TC_OVF_EN = 12'h434;
  localparam logic [11:0] ADDR_LINK_STAT = 12'h435;
  localparam logic [11:0] ADDR_LINK_EN = 12'h445;
  localparam logic [11:0] ADDR_MASTER_STAT = 12'h455;
  localparam logic [11:0] ADDR_GRP_SUMMARY = 12'h457;

  // ----------------------------------------
  // link status fields
  // ----------------------------------------
  localparam int LS_OVF = 0;
  localparam int LS_CD_IN = 1;
  localparam int LS_FL_IN = 2;
  localparam int LS_DD_IN = 3;
  localparam int LS_VIOL = 4;
  localparam int LS_CHG = 5;
  localparam int LS_PRE_OVF = 6;
  localparam int LS_TXEV = 7;
  localparam int LS_GRP_OVF = 8;
  localparam int LS_CD_OUT = 9;
  localparam int LS_FL_OUT = 10;
  localparam int LS_DD_OUT = 11;
  localparam logic [11:0] LS_LATCH_MASK = 12'hE7E;

  // ----------------------------------------
  // other fields and reset values
  // ----------------------------------------
  localparam int TC_FIFO = 12;
  localparam int GL_FIFO = 4;
  localparam int TXH_READY_LSB = 8;
  localparam logic [15:0] REG_RST = 16'h0000;
  localparam logic IRQ_IDLE = 1'b1;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  function automatic logic reg_hit(input logic [11:0] a, input logic [11:0] base, input int idx);
    reg_hit = (a == 12'(base + 12'(idx)));
  endfunction

endpackage

// ==== imai_rw_bank.sv ====
// bank of plain read/write enable registers
module imai_rw_bank #(
  parameter int N = 1,
  parameter int W = 16,
  parameter logic [11:0] BASE = 12'h000
) (
  input wire logic clk,
  input wire logic rst,
  imai_bus_if.bank bus,
  output logic [N-1:0][W-1:0] q
);

  typedef struct packed {
    logic [N-1:0][W-1:0] q;
  } imai_rw_s;

  imai_rw_s st_ff;
  imai_rw_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    for (int i = 0; i < N; i++) begin
      if (bus.wr && imai_pkg::reg_hit(bus.addr, BASE, i)) begin
        nxt_st.q[i] = bus.wdata[W-1:0];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '{q: '{default: imai_pkg::REG_RST[W-1:0]}};
    end else if (bus.ce) begin
      st_ff <= nxt_st;
    end
  end

  assign q = st_ff.q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_rw_store;
    bus.ce && bus.wr && imai_pkg::reg_hit(bus.addr, BASE, N - 1)
      |=> q[N-1] == $past(bus.wdata[W-1:0]);
  endproperty
  a_rw_store: assert property (p_rw_store) else $error("enable write not stored");

endmodule
